/* src/oled_host_bus_master.sv */
// Purpose: Host end that drives the 8-bit display bus from a request port.
// Assumes: Mode is static; device answers reads within one strobe phase.
// Notes: Each phase lasts PHASE_CYC cycles; serial reads are not possible.
`timescale 1ns/1ps
`include "host_port_regs.svh"
module oled_host_bus_master (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Static configuration
    input wire host_port_pkg::bus_mode_e mode,
    // Request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_dc,
    input wire logic [7:0] req_data,
    // Read answer
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // Controller reset request, level
    input wire logic ctrl_reset_req,
    // Pins toward the display
    host_bus_if.host bus
);

    // ==========================================================
    // State registers
    host_port_pkg::host_state_s s_q;
    host_port_pkg::host_state_s s_d;
    logic tick; // Phase end enable pulse

    // ==========================================================
    // Sequencer
    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.ctrl_reset_n = ~ctrl_reset_req;
        tick = (s_q.tick_cnt == 4'(`PHASE_CYC - 1));
        if (s_q.phase != host_port_pkg::PH_IDLE) begin
            s_d.tick_cnt = tick ? 4'h0 : s_q.tick_cnt + 4'h1;
        end
        unique case (s_q.phase)
            host_port_pkg::PH_IDLE: begin
                if (req_valid) begin
                    s_d.write = req_write;
                    s_d.dc = req_dc;
                    s_d.data = req_data;
                    s_d.bit_idx = 3'h0;
                    s_d.tick_cnt = 4'h0;
                    if (mode == host_port_pkg::MODE_SERIAL && !req_write) begin
                        // No read path in serial mode
                        s_d.rsp_valid = 1'b1;
                        s_d.rsp_data = `SERIAL_RD_DATA;
                    end else begin
                        s_d.phase = host_port_pkg::PH_SETUP;
                        s_d.cs_n = 1'b0;
                        s_d.oe = req_write;
                        // Command write arms, first data read consumes
                        if (req_write && !req_dc) begin
                            s_d.dummy_arm = 1'b1;
                        end
                        if (!req_write && req_dc && s_q.dummy_arm) begin
                            s_d.dummy = 1'b1;
                            s_d.dummy_arm = 1'b0;
                        end
                        if (mode == host_port_pkg::MODE_68XX) begin
                            s_d.strobe_wr = ~req_write;
                        end
                        if (mode == host_port_pkg::MODE_SERIAL) begin
                            s_d.dout = {6'h00, req_data[7], 1'b0};
                        end else begin
                            s_d.dout = req_data;
                        end
                    end
                end
            end
            host_port_pkg::PH_SETUP: begin
                if (tick) begin
                    s_d.phase = host_port_pkg::PH_STROBE;
                    unique case (mode)
                        host_port_pkg::MODE_68XX: s_d.strobe_rd = 1'b1;
                        host_port_pkg::MODE_80XX: begin
                            s_d.strobe_rd = s_q.write;
                            s_d.strobe_wr = ~s_q.write;
                        end
                        default: s_d.dout[`SCLK_BIT] = 1'b1;
                    endcase
                end
            end
            host_port_pkg::PH_STROBE: begin
                if (tick) begin
                    s_d.phase = host_port_pkg::PH_HOLD;
                    if (!s_q.write) begin
                        s_d.rsp_data = bus.host_bus_lines;
                    end
                    unique case (mode)
                        host_port_pkg::MODE_68XX: s_d.strobe_rd = 1'b0;
                        host_port_pkg::MODE_80XX: begin
                            s_d.strobe_rd = 1'b1;
                            s_d.strobe_wr = 1'b1;
                        end
                        default: s_d.dout[`SCLK_BIT] = 1'b0;
                    endcase
                end
            end
            host_port_pkg::PH_HOLD: begin
                if (tick) begin
                    if (mode == host_port_pkg::MODE_SERIAL && s_q.bit_idx != `SER_LAST) begin
                        // Next serial bit, MSB first on data bit one
                        s_d.bit_idx = s_q.bit_idx + 3'h1;
                        s_d.data = {s_q.data[6:0], 1'b0};
                        s_d.dout = {6'h00, s_q.data[6], 1'b0};
                        s_d.phase = host_port_pkg::PH_SETUP;
                    end else if (s_q.dummy) begin
                        // Dummy read done; repeat for the real byte
                        s_d.dummy = 1'b0;
                        s_d.phase = host_port_pkg::PH_SETUP;
                    end else begin
                        s_d.phase = host_port_pkg::PH_IDLE;
                        s_d.cs_n = 1'b1;
                        s_d.oe = 1'b0;
                        s_d.rsp_valid = ~s_q.write;
                    end
                end
            end
        endcase
        if (!reset_n) begin
            s_d = '0;
            s_d.cs_n = 1'b1;
            s_d.strobe_rd = (mode == host_port_pkg::MODE_80XX);
            s_d.strobe_wr = (mode != host_port_pkg::MODE_SERIAL);
            s_d.ctrl_reset_n = 1'b0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    // ==========================================================
    // Outputs
    assign req_ready = (s_q.phase == host_port_pkg::PH_IDLE);
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_data = s_q.rsp_data;
    assign bus.chip_sel_n = s_q.cs_n;
    assign bus.strobe_rd = s_q.strobe_rd;
    assign bus.strobe_wr = s_q.strobe_wr;
    assign bus.data_cmd_select = s_q.dc;
    assign bus.host_dout = s_q.dout;
    assign bus.host_oe = s_q.oe;
    assign bus.ctrl_reset_n = s_q.ctrl_reset_n;

endmodule

/* src/host_port_regs.svh */
// Purpose: Constants shared by both ends of the host bus port.
// Assumes: Clock clk_sys at 100 MHz; widths fixed at documented values.
// Notes: Included by bare name wherever the constants are used.
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ==========================================================
// Bus geometry
`define BUS_W 8
`define BUS_IDLE 8'hff
`define SER_LAST 3'h7
`define SCLK_BIT 0
`define SER_IN_BIT 1

// ==========================================================
// Host strobe timing
`define PHASE_NS 40
`define CLK_NS 10
`define PHASE_CYC ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define SERIAL_RD_DATA 8'h00

`endif

/* src/host_port_pkg.sv */
// Purpose: Types shared by both ends of the host bus port.
// Assumes: Constants come from host_port_regs.svh.
// Notes: Nothing here is imported; users write host_port_pkg::name.
package host_port_pkg;

    // ==========================================================
    // Static bus mode, fixed while running
    typedef enum logic [1:0] {
        MODE_68XX,
        MODE_80XX,
        MODE_SERIAL
    } bus_mode_e;

    // ==========================================================
    // Host sequencer phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SETUP,
        PH_STROBE,
        PH_HOLD
    } host_phase_e;

    // Whole state of the device end
    typedef struct packed {
        logic strobe_rd_q;  // Previous read / enable pin level
        logic strobe_wr_q;  // Previous write / direction pin level
        logic sclk_q;       // Previous serial clock level
        logic [7:0] bus_q;  // Bus value one cycle back
        logic [7:0] shift;  // Serial shift register
        logic [2:0] bit_cnt; // Serial bits taken so far
        logic cmd_valid;    // Command byte pulse
        logic data_valid;   // Display data byte pulse
        logic [7:0] byte_out; // Last received byte
        logic [7:0] rd_buf; // Display read pipeline byte
        logic rd_adv;       // Read pointer advance pulse
        logic [7:0] dout;   // Bus value driven on reads
        logic oe;           // Bus drive enable
        logic init;         // Initialisation in progress
    } dev_state_s;

    // Whole state of the host end
    typedef struct packed {
        host_phase_e phase; // Sequencer phase
        logic [3:0] tick_cnt; // Phase length divider
        logic write;        // Current transfer is a write
        logic dc;           // Current transfer is data
        logic [7:0] data;   // Write byte, shifted in serial mode
        logic [2:0] bit_idx; // Serial bit index
        logic dummy_arm;    // Next data read needs a dummy read
        logic dummy;        // Current read is the dummy one
        logic rsp_valid;    // Read answer pulse
        logic [7:0] rsp_data; // Read answer byte
        logic cs_n;         // Chip select pin
        logic strobe_rd;    // Enable or read strobe pin
        logic strobe_wr;    // Direction or write strobe pin
        logic [7:0] dout;   // Bus value driven
        logic oe;           // Bus drive enable
        logic ctrl_reset_n; // Reset pin toward the device
    } host_state_s;

endpackage

/* src/host_bus_if.sv */
// Purpose: Pin bundle between host and display controller ends.
// Assumes: Both ends run on clk_sys; pins sampled synchronously.
// Notes: Resolves the shared data lines from the two drive enables.
`timescale 1ns/1ps
`include "host_port_regs.svh"
interface host_bus_if;
    // Host side drive of the shared data lines
    logic [7:0] host_dout;
    logic host_oe;
    // Device side drive of the shared data lines
    logic [7:0] dev_dout;
    logic dev_oe;
    // Control pins, all driven by the host
    logic strobe_rd;
    logic strobe_wr;
    logic chip_sel_n;
    logic data_cmd_select;
    logic ctrl_reset_n;
    // Resolved level of the data lines, pulled high when undriven
    logic [7:0] host_bus_lines;

    assign host_bus_lines = host_oe ? host_dout : (dev_oe ? dev_dout : `BUS_IDLE);

    modport device (
        input strobe_rd, strobe_wr, chip_sel_n, data_cmd_select, ctrl_reset_n,
        input host_bus_lines,
        output dev_dout, dev_oe
    );
    modport host (
        output strobe_rd, strobe_wr, chip_sel_n, data_cmd_select, ctrl_reset_n,
        output host_dout, host_oe,
        input host_bus_lines
    );
endinterface

/* src/oled_host_bus_port.sv */
// Purpose: Display controller end of the 8-bit host bus port.
// Assumes: Pins are synchronous to clk_sys; mode is static while running.
// Notes: Bytes leave as one-cycle pulses; reads use a one-byte pipeline.
`timescale 1ns/1ps
`include "host_port_regs.svh"

module oled_host_bus_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Static configuration
    input wire host_port_pkg::bus_mode_e mode,
    // Pins toward the host
    host_bus_if.device bus,
    // Received bytes
    output logic cmd_valid,
    output logic data_valid,
    output logic [7:0] rx_byte,
    // Read-back sources
    input wire logic [7:0] status_byte,
    input wire logic [7:0] disp_rd_data,
    output logic disp_rd_adv,
    // Controller initialisation
    output logic init_active
);

    // ==========================================================
    // State registers
    host_port_pkg::dev_state_s s_q;
    host_port_pkg::dev_state_s s_d;

    // Decoded pin events, computed each cycle
    logic sel;           // Chip selected
    logic is_68;         // 68xx bus in use
    logic is_80;         // 80xx bus in use
    logic is_ser;        // Serial bus in use
    logic en_fall;       // 68xx enable falling edge
    logic rd_rise;       // 80xx read strobe rising edge
    logic wr_rise;       // 80xx write strobe rising edge
    logic sclk_rise;     // Serial clock rising edge
    logic par_write;     // Parallel write completes
    logic par_read;      // Parallel read completes
    logic drive;         // Host asks for read data now
    logic [7:0] ser_byte; // Serial byte once complete

    // ==========================================================
    // Pin event decode
    always_comb begin
        // Mode decode; mode never changes in operation
        is_68 = (mode == host_port_pkg::MODE_68XX);
        is_80 = (mode == host_port_pkg::MODE_80XX);
        is_ser = (mode == host_port_pkg::MODE_SERIAL);
        // Nothing counts unless chip select is low
        sel = ~bus.chip_sel_n;
        // Enable high held, now low: end of a 68xx transfer
        en_fall = is_68 & sel & s_q.strobe_rd_q & ~bus.strobe_rd;
        // Read strobe was low, now high: end of an 80xx read
        rd_rise = is_80 & sel & ~s_q.strobe_rd_q & bus.strobe_rd;
        // Write strobe was low, now high: end of an 80xx write
        wr_rise = is_80 & sel & ~s_q.strobe_wr_q & bus.strobe_wr;
        // Serial clock on data bit zero
        sclk_rise = is_ser & sel & ~s_q.sclk_q & bus.host_bus_lines[`SCLK_BIT];
        // Direction pin low during the enable means write
        par_write = (en_fall & ~s_q.strobe_wr_q) | wr_rise;
        par_read = (en_fall & s_q.strobe_wr_q) | rd_rise;
        // Drive while the host holds a read strobe
        if (is_68) begin
            drive = sel & bus.strobe_rd & bus.strobe_wr;
        end else if (is_80) begin
            drive = sel & ~bus.strobe_rd;
        end else begin
            drive = 1'b0;
        end
        // Serial data bit one enters at the bottom, MSB first
        ser_byte = {s_q.shift[6:0], bus.host_bus_lines[`SER_IN_BIT]};
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        s_d = s_q;
        // Pulses last one cycle
        s_d.cmd_valid = 1'b0;
        s_d.data_valid = 1'b0;
        s_d.rd_adv = 1'b0;
        // Pin history for edge detection
        s_d.strobe_rd_q = bus.strobe_rd;
        s_d.strobe_wr_q = bus.strobe_wr;
        s_d.sclk_q = bus.host_bus_lines[`SCLK_BIT];
        // Bus value held while the strobe was still active
        s_d.bus_q = bus.host_bus_lines;
        s_d.init = 1'b0;

        if (par_write) begin
            // Byte from the cycle before the closing edge
            s_d.byte_out = s_q.bus_q;
            if (bus.data_cmd_select) begin
                s_d.data_valid = 1'b1;
            end else begin
                s_d.cmd_valid = 1'b1;
            end
        end

        if (par_read && bus.data_cmd_select) begin
            // Hand over the prefetched byte, fetch the next one
            s_d.rd_buf = disp_rd_data;
            s_d.rd_adv = 1'b1;
        end

        if (is_ser) begin
            if (!sel) begin
                // Deselect aborts a partial serial byte
                s_d.bit_cnt = 3'h0;
            end else if (sclk_rise) begin
                s_d.shift = ser_byte;
                s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                if (s_q.bit_cnt == `SER_LAST) begin
                    // Eighth bit: byte complete, steered by data/command
                    s_d.byte_out = ser_byte;
                    s_d.data_valid = bus.data_cmd_select;
                    s_d.cmd_valid = ~bus.data_cmd_select;
                end
            end
        end

        // Read drive: status for command reads, pipeline for data
        s_d.oe = drive;
        s_d.dout = bus.data_cmd_select ? s_q.rd_buf : status_byte;

        // Either reset initialises the whole controller side
        if (!reset_n || !bus.ctrl_reset_n) begin
            s_d = '0;
            s_d.strobe_rd_q = bus.strobe_rd;
            s_d.strobe_wr_q = bus.strobe_wr;
            s_d.sclk_q = bus.host_bus_lines[`SCLK_BIT];
            s_d.rd_buf = `BUS_IDLE;
            s_d.init = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign bus.dev_dout = s_q.dout;
    assign bus.dev_oe = s_q.oe;
    assign cmd_valid = s_q.cmd_valid;
    assign data_valid = s_q.data_valid;
    assign rx_byte = s_q.byte_out;
    assign disp_rd_adv = s_q.rd_adv;
    assign init_active = s_q.init;

endmodule

/* tb/host_bus_props.sv */
// Purpose: Timing checks on the pins between the host and display ends.
// Assumes: All pins are sampled on clk_sys; mode only changes in reset.
// Notes: Instantiated beside the interface in the bench top.
`timescale 1ns/1ps
module host_bus_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Static configuration
    input wire host_port_pkg::bus_mode_e mode,
    // Bus pins
    input wire logic [7:0] host_dout,
    input wire logic host_oe,
    input wire logic [7:0] dev_dout,
    input wire logic dev_oe,
    input wire logic strobe_rd,
    input wire logic strobe_wr,
    input wire logic chip_sel_n,
    input wire logic data_cmd_select,
    input wire logic ctrl_reset_n,
    input wire logic [7:0] host_bus_lines
);
    // ==========================================================
    // Common clock and reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Mode flags
    wire logic m68 = (mode == host_port_pkg::MODE_68XX);
    wire logic m80 = (mode == host_port_pkg::MODE_80XX);
    // Write strobe low for one full phase
    sequence wr_low_phase;
        (!strobe_wr && !chip_sel_n) [*4];
    endsequence
    // Enable high for one full phase, direction steady
    sequence e_high_phase;
        (strobe_rd && !chip_sel_n && $stable(strobe_wr)) [*4];
    endsequence
    // ==========================================================
    // Assertions
    chk_no_bus_fight: assert property (!(host_oe && dev_oe))
        else $error("both ends drive the data lines");
    chk_quiet_when_free: assert property (chip_sel_n && $past(chip_sel_n) |-> !dev_oe)
        else $error("device drives while deselected");
    chk_read68_drive: assert property (
        (m68 && !chip_sel_n && strobe_rd && strobe_wr) [*3] |-> dev_oe)
        else $error("device silent in enable read");
    chk_read80_drive: assert property (
        (m80 && !chip_sel_n && !strobe_rd) [*3] |-> dev_oe)
        else $error("device silent in strobe read");
    chk_write80_quiet: assert property ((m80 && !strobe_wr) [*2] |-> !dev_oe)
        else $error("device drives during a write");
    chk_wr_strobe_len: assert property (
        m80 && $fell(strobe_wr) |-> wr_low_phase ##1 strobe_wr)
        else $error("write strobe phase wrong");
    chk_e_strobe_len: assert property (
        m68 && $rose(strobe_rd) |-> e_high_phase ##1 !strobe_rd)
        else $error("enable phase wrong");
    chk_strobe_needs_cs: assert property (
        (m68 && strobe_rd) || (m80 && !(strobe_rd && strobe_wr)) |-> !chip_sel_n)
        else $error("strobe active without select");
    chk_write_held: assert property (m80 && !strobe_wr |->
        host_oe && $stable(host_dout) && $stable(data_cmd_select))
        else $error("write byte moved under strobe");
    chk_serial_no_drive: assert property (
        mode == host_port_pkg::MODE_SERIAL |-> !dev_oe)
        else $error("device drives in serial mode");
endmodule

/* tb/test_oled_host_bus_port.sv */
// Purpose: Drives host requests through both ends and checks bytes on each side.
// Assumes: Mode changes only while reset_n is low.
// Notes: Display memory is modelled as a function of the read pointer.
`timescale 1ns/1ps
`include "host_port_regs.svh"
module test_oled_host_bus_port;
    // ==========================================================
    // Stimulus and observed signals
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    host_port_pkg::bus_mode_e mode = host_port_pkg::MODE_68XX;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_dc = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic ctrl_reset_req = 1'b0;
    logic [7:0] status_byte = 8'h00;
    logic [7:0] disp_rd_data = 8'h00;
    logic req_ready, rsp_valid, cmd_valid, data_valid, disp_rd_adv, init_active;
    logic [7:0] rsp_data, rx_byte;
    integer seed = 89670;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] ptr = 8'h00; // Memory model pointer
    logic [8:0] dev_q[$], wire_q[$], rsp_q[$]; // Observed bytes, dc on top, zero on top for rsp_q
    logic [7:0] buf_e, ptr_e, bus_q, sh; // Expected read pipeline, wire shifter
    logic armed, d0_q, wr_q, e_q; // Dummy read pending, previous pin levels
    int nbit = 0;
    logic [31:0] r;
    // Free running clock
    always #5 clk_sys = ~clk_sys;
    // ==========================================================
    // Both ends facing each other
    host_bus_if bus_if ();
    oled_host_bus_port oled_host_bus_port_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .mode(mode), .bus(bus_if), .cmd_valid(cmd_valid), .data_valid(data_valid),
        .rx_byte(rx_byte), .status_byte(status_byte), .disp_rd_data(disp_rd_data),
        .disp_rd_adv(disp_rd_adv), .init_active(init_active));
    oled_host_bus_master oled_host_bus_master_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .mode(mode), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_dc(req_dc), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .ctrl_reset_req(ctrl_reset_req), .bus(bus_if));
    host_bus_props host_bus_props_inst (.clk_sys(clk_sys), .reset_n(reset_n), .mode(mode),
        .host_dout(bus_if.host_dout), .host_oe(bus_if.host_oe), .dev_dout(bus_if.dev_dout),
        .dev_oe(bus_if.dev_oe), .strobe_rd(bus_if.strobe_rd), .strobe_wr(bus_if.strobe_wr),
        .chip_sel_n(bus_if.chip_sel_n), .data_cmd_select(bus_if.data_cmd_select),
        .ctrl_reset_n(bus_if.ctrl_reset_n), .host_bus_lines(bus_if.host_bus_lines));
    // ==========================================================
    // Helpers
    // Display memory contents
    function automatic logic [7:0] mem_byte(input logic [7:0] a);
        return a * 8'h1d + 8'h5a;
    endfunction
    // Oldest entry, unknown when nothing arrived
    function automatic logic [8:0] pop9(ref logic [8:0] q[$]);
        if (q.size() == 0) begin
            return 9'hxx;
        end
        return q.pop_front();
    endfunction
    // Memory presents the byte at the pointer
    always @(negedge clk_sys) disp_rd_data <= mem_byte(ptr);
    // Collect pulses from both user sides
    always @(posedge clk_sys) begin
        if (disp_rd_adv === 1'b1) ptr <= ptr + 8'h01;
        if (cmd_valid === 1'b1 || data_valid === 1'b1) dev_q.push_back({data_valid, rx_byte});
        if (rsp_valid === 1'b1) rsp_q.push_back({1'b0, rsp_data});
    end
    // Decode bytes straight off the pins for each mode
    always @(posedge clk_sys) begin
        bus_q <= bus_if.host_bus_lines;
        wr_q <= bus_if.strobe_wr;
        e_q <= bus_if.strobe_rd;
        d0_q <= bus_if.host_bus_lines[`SCLK_BIT];
        if (bus_if.chip_sel_n !== 1'b0) begin
            nbit <= 0;
        end else if (mode == host_port_pkg::MODE_80XX && wr_q === 1'b0
                     && bus_if.strobe_wr === 1'b1) begin
            wire_q.push_back({bus_if.data_cmd_select, bus_q});
        end else if (mode == host_port_pkg::MODE_68XX && e_q === 1'b1
                     && bus_if.strobe_rd === 1'b0 && bus_if.strobe_wr === 1'b0) begin
            wire_q.push_back({bus_if.data_cmd_select, bus_q});
        end else if (mode == host_port_pkg::MODE_SERIAL && d0_q === 1'b0
                     && bus_if.host_bus_lines[`SCLK_BIT] === 1'b1) begin
            sh <= {sh[6:0], bus_if.host_bus_lines[`SER_IN_BIT]};
            nbit <= nbit + 1;
            if (nbit == 7) begin
                wire_q.push_back({bus_if.data_cmd_select, sh[6:0],
                                  bus_if.host_bus_lines[`SER_IN_BIT]});
            end
        end
    end
    // ==========================================================
    // Compare and report
    task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================
    // Request port driver, bounded waits only
    task automatic wait_ready();
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        if (i >= 200) begin
            check_bit("req_ready", 1'b1, req_ready);
            finish_test();
        end
    endtask
    task automatic do_req(input logic w, input logic dc, input logic [7:0] d);
        wait_ready();
        req_valid = 1'b1;
        req_write = w;
        req_dc = dc;
        req_data = d;
        @(posedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
        wait_ready();
        repeat (4) @(negedge clk_sys);
    endtask
    // Write one byte and follow it to the wire and the device
    task automatic op_write(input logic dc, input logic [7:0] d);
        do_req(1'b1, dc, d);
        if (!dc) armed = 1'b1;
        check_val("wire byte", {dc, d}, pop9(wire_q));
        check_val("rx byte", {dc, d}, pop9(dev_q));
    endtask
    // Read one byte; data reads go through the one-byte pipeline
    task automatic op_read(input logic dc);
        logic [7:0] e;
        if (mode == host_port_pkg::MODE_SERIAL) begin
            e = `SERIAL_RD_DATA;
        end else if (!dc) begin
            e = status_byte;
        end else begin
            if (armed) begin
                buf_e = mem_byte(ptr_e);
                ptr_e++;
            end
            e = buf_e;
            buf_e = mem_byte(ptr_e);
            ptr_e++;
            armed = 1'b0;
        end
        do_req(1'b0, dc, 8'h00);
        check_val("read byte", {1'b0, e}, pop9(rsp_q));
    endtask
    // ==========================================================
    // Main sequence, every mode set during reset
    initial begin
        ptr_e = 8'h00;
        for (int m = 0; m < 3; m++) begin
            reset_n = 1'b0;
            mode = host_port_pkg::bus_mode_e'(m);
            armed = 1'b0;
            buf_e = 8'hff;
            status_byte = 8'($random(seed));
            repeat (4) @(negedge clk_sys);
            check_bit("init_active", 1'b1, init_active);
            reset_n = 1'b1;
            @(negedge clk_sys);
            wire_q.delete();
            dev_q.delete();
            rsp_q.delete();
            // Corners: read before any command, extreme bytes, dummy read
            op_read(1'b1);
            op_write(1'b0, 8'h00);
            op_write(1'b1, 8'hff);
            op_read(1'b0);
            op_read(1'b1);
            op_read(1'b1);
            // Controller reset pin in mid-run
            ctrl_reset_req = 1'b1;
            repeat (4) @(negedge clk_sys);
            check_bit("init_active", 1'b1, init_active);
            ctrl_reset_req = 1'b0;
            buf_e = 8'hff;
            repeat (4) @(negedge clk_sys);
            check_bit("init_active", 1'b0, init_active);
            // Random traffic
            repeat (10) begin
                r = $random(seed);
                if (r[1]) begin
                    op_write(r[0], r[15:8]);
                end else begin
                    op_read(r[0]);
                end
            end
            $display("test mode %0d done", m);
        end
        finish_test();
    end
endmodule
